// >>> lgr_core.sv
// lgr_core: identity word, crc check, command gating, speed switch, page map
// assumes: a bit engine outside delivers decoded rom commands and byte accesses
// Operation
// - identity is family, serial, range, crc
// - crc uses x8+x5+x4+1 shift register
// - crc stages cleared before first bit
// - bits shifted lsb first, crc after 56
// - residue zero after crc bits means valid
// - every byte moves least significant bit first
// - memory commands need completed rom command
// - overdrive rom command switches to overdrive speed
// - memory pages 0-15, register page 16
// - excursion 17-19, histogram 64-67, log 128-191
// - remaining pages reserved, no storage
// - writes to memory pass through scratchpad
// - user writes to page 17+ rejected
// - mission blocks timekeeping and control writes
// - histogram 63 bins in 126 bytes
// - log 2048 samples at 1-255 minutes
// - 24 excursion entries in 96 bytes
// - first protected write ends mission, no change
`timescale 1ns/100ps
`default_nettype none
module lgr_core #(
    parameter logic [7:0] FAMILY = 8'h5A, // arbitrary value
    parameter logic [35:0] SERIAL = 36'h123456789, // arbitrary value
    parameter logic [11:0] RANGE = 12'hA5A // arbitrary value
) (
    input wire logic ref_clk, // 125 MHz clock
    input wire logic rst, // sync reset, active high
    input wire logic bus_reset, // one-cycle bus reset seen by bit engine
    input wire logic rom_done, // rom command completed successfully
    input wire lgr_pkg::lgr_rom_cmd_type rom_cmd, // which rom command
    input wire logic mem_req, // memory command access request
    input wire logic mem_wr, // access is a write
    input wire logic [12:0] mem_addr, // page and byte offset
    input wire logic mission_start, // internal control begins a mission
    input wire logic id_bit_req, // request next identity bit
    input wire logic [7:0] tx_byte, // byte to serialise
    input wire logic tx_load, // load tx byte
    input wire logic tx_shift, // advance tx serialiser
    output logic tx_bit, // current tx bit, lsb first
    output logic id_bit, // identity bit, lsb first
    output logic id_valid, // identity crc residue zero after 64 bits
    output logic [7:0] id_crc, // computed crc of lower 56 bits
    output logic overdrive, // overdrive speed active
    output logic mem_enabled, // memory commands accepted
    output logic mem_ack, // access accepted, one cycle
    output logic mem_nak, // access refused, one cycle
    output logic sp_write, // write goes to scratchpad, one cycle
    output logic reserved_hit, // access hit reserved page, one cycle
    output lgr_pkg::lgr_region_type region, // decoded region of access
    output logic mission_active, // mission in progress
    output logic mission_stop // one-cycle mission termination
);
    import lgr_pkg::*;
    // ----------------------------------------------------------------
    // identity word and crc
    // ----------------------------------------------------------------
    logic [ID_W-1:0] id_word;
    logic [BIT_CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] crc_lo_reg, crc_lo_next;
    logic crc_clr, crc_zero, id_valid_reg, id_valid_next, id_bit_reg, id_bit_next;
    logic boot_reg, boot_next, built_reg, built_next;
    logic [7:0] crc_val;
    logic [FAM_W+SER_W+RNG_W-1:0] id_data;
    assign id_data = {RANGE, SERIAL, FAMILY};
    function automatic logic [7:0] crc_of(input logic [DATA_W-1:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < DATA_W; i++) begin
            c = lgr_crc_step(c, d[i]);
        end
        crc_of = c;
    endfunction
    assign id_word = {crc_of(id_data), id_data};
    lgr_crc8 u_crc (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(crc_clr),
        .shift_en(id_bit_req),
        .bit_in(id_word[bit_cnt_reg[5:0]]),
        .crc(crc_val),
        .zero(crc_zero)
    );
    assign crc_clr = boot_reg | bus_reset | (rom_done & (rom_cmd == RC_READ));
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        crc_lo_next = crc_lo_reg;
        id_valid_next = id_valid_reg;
        id_bit_next = id_bit_reg;
        boot_next = 1'b0;
        built_next = built_reg;
        if (crc_clr) begin
            bit_cnt_next = '0;
            id_bit_next = id_word[0];
        end else if (id_bit_req) begin
            bit_cnt_next = (bit_cnt_reg == BIT_ALL_LAST) ? '0 : bit_cnt_reg + 7'h01;
            id_bit_next = id_word[bit_cnt_next[5:0]];
            if (bit_cnt_reg == BIT_DATA_LAST) begin
                crc_lo_next = lgr_crc_step(crc_val, id_word[bit_cnt_reg[5:0]]);
            end
            if (bit_cnt_reg == BIT_ALL_LAST) begin
                built_next = 1'b1;
                id_valid_next = (lgr_crc_step(crc_val, id_word[ID_W-1]) == CRC_INIT);
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_cnt_reg <= '0;
            crc_lo_reg <= CRC_INIT;
            id_valid_reg <= 1'b0;
            id_bit_reg <= 1'b0;
            boot_reg <= 1'b1;
            built_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            crc_lo_reg <= crc_lo_next;
            id_valid_reg <= id_valid_next;
            id_bit_reg <= id_bit_next;
            boot_reg <= boot_next;
            built_reg <= built_next;
        end
    end
    assign id_bit = id_bit_reg;
    assign id_valid = id_valid_reg & built_reg;
    assign id_crc = crc_lo_reg;
    // ----------------------------------------------------------------
    // byte serialiser
    // ----------------------------------------------------------------
    logic [7:0] tx_sh_reg, tx_sh_next;
    always_comb begin
        tx_sh_next = tx_sh_reg;
        if (tx_load) begin
            tx_sh_next = tx_byte;
        end else if (tx_shift) begin
            tx_sh_next = {1'b0, tx_sh_reg[7:1]};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_sh_reg <= 8'h00;
        end else begin
            tx_sh_reg <= tx_sh_next;
        end
    end
    assign tx_bit = tx_sh_reg[0];
    // ----------------------------------------------------------------
    // rom gating and speed
    // ----------------------------------------------------------------
    logic od_reg, od_next, mem_en_reg, mem_en_next;
    always_comb begin
        od_next = od_reg;
        mem_en_next = mem_en_reg;
        if (bus_reset) begin
            mem_en_next = 1'b0;
        end else if (rom_done && rom_cmd != RC_NONE) begin
            mem_en_next = 1'b1;
            if (!od_reg && (rom_cmd == RC_OD_SKIP || rom_cmd == RC_OD_MATCH)) begin
                od_next = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            od_reg <= 1'b0;
            mem_en_reg <= 1'b0;
        end else begin
            od_reg <= od_next;
            mem_en_reg <= mem_en_next;
        end
    end
    assign overdrive = od_reg;
    assign mem_enabled = mem_en_reg;
    // ----------------------------------------------------------------
    // page decoder and write protection
    // ----------------------------------------------------------------
    function automatic lgr_region_type decode(input logic [7:0] pg);
        if (pg <= PG_GP_LAST) begin
            decode = RG_GP;
        end else if (pg == PG_REG) begin
            decode = RG_REG;
        end else if (pg >= PG_EXC_FIRST && pg <= PG_EXC_LAST) begin
            decode = RG_EXC;
        end else if (pg >= PG_HIST_FIRST && pg <= PG_HIST_LAST) begin
            decode = RG_HIST;
        end else if (pg >= PG_LOG_FIRST && pg <= PG_LOG_LAST) begin
            decode = RG_LOG;
        end else begin
            decode = RG_RSVD;
        end
    endfunction
    lgr_region_type rg_now, rg_reg, rg_next;
    logic ack_reg, ack_next, nak_reg, nak_next, spw_reg, spw_next;
    logic rsv_reg, rsv_next, mis_reg, mis_next, stop_reg, stop_next;
    logic prot;
    assign rg_now = decode(mem_addr[12:5]);
    assign prot = (rg_now == RG_REG) && (mem_addr[4:0] <= REG_PROT_LAST);
    always_comb begin
        rg_next = rg_reg;
        ack_next = 1'b0;
        nak_next = 1'b0;
        spw_next = 1'b0;
        rsv_next = 1'b0;
        stop_next = 1'b0;
        mis_next = mis_reg;
        if (mission_start) begin
            mis_next = 1'b1;
        end
        if (mem_req) begin
            rg_next = rg_now;
            rsv_next = (rg_now == RG_RSVD);
            if (!mem_en_reg) begin
                nak_next = 1'b1;
            end else if (!mem_wr) begin
                ack_next = !rsv_next;
                nak_next = rsv_next;
            end else if (rg_now != RG_GP && rg_now != RG_REG) begin
                nak_next = 1'b1;
            end else if (mis_reg && prot) begin
                nak_next = 1'b1;
                mis_next = 1'b0;
                stop_next = 1'b1;
            end else begin
                ack_next = 1'b1;
                spw_next = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rg_reg <= RG_GP;
            ack_reg <= 1'b0;
            nak_reg <= 1'b0;
            spw_reg <= 1'b0;
            rsv_reg <= 1'b0;
            mis_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            rg_reg <= rg_next;
            ack_reg <= ack_next;
            nak_reg <= nak_next;
            spw_reg <= spw_next;
            rsv_reg <= rsv_next;
            mis_reg <= mis_next;
            stop_reg <= stop_next;
        end
    end
    assign region = rg_reg;
    assign mem_ack = ack_reg;
    assign mem_nak = nak_reg;
    assign sp_write = spw_reg;
    assign reserved_hit = rsv_reg;
    assign mission_active = mis_reg;
    assign mission_stop = stop_reg;
endmodule // lgr_core
`default_nettype wire

// >>> lgr_core_sva.sv
// lgr_core_sva: port-level checks for lgr_core
// assumes: bound to lgr_core by the bench top; one clock domain
`timescale 1ns/100ps
`default_nettype none
module lgr_core_sva
    import lgr_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic rst, // sync reset
    input wire logic bus_reset, // bus reset pulse
    input wire logic rom_done, // rom command done
    input wire lgr_pkg::lgr_rom_cmd_type rom_cmd, // rom command
    input wire logic mem_req, // access request
    input wire logic mem_wr, // access is write
    input wire logic [12:0] mem_addr, // page and offset
    input wire logic mission_start, // mission begins
    input wire logic [7:0] tx_byte, // byte to send
    input wire logic tx_load, // load byte
    input wire logic tx_bit, // sent bit
    input wire logic overdrive, // speed level
    input wire logic mem_enabled, // memory gate
    input wire logic mem_ack, // accepted
    input wire logic mem_nak, // refused
    input wire logic sp_write, // scratchpad write
    input wire logic reserved_hit, // reserved page
    input wire lgr_pkg::lgr_region_type region, // decoded region
    input wire logic mission_active, // mission level
    input wire logic mission_stop // mission ended
);
    import lgr_pkg::*;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [7:0] pg;
    logic go;
    logic rsvd;
    assign pg = mem_addr[12:5];
    assign go = mem_req && !bus_reset && !rom_done && !mission_start;
    assign rsvd = (pg > PG_EXC_LAST && pg < PG_HIST_FIRST) ||
        (pg > PG_HIST_LAST && pg < PG_LOG_FIRST) || pg > PG_LOG_LAST;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    answer_once_a: assert property (mem_req |=> mem_ack ^ mem_nak)
        else $error("access not answered exactly once");
    answer_cause_a: assert property ((mem_ack || mem_nak) |-> $past(mem_req))
        else $error("answer without request");
    gate_closed_a: assert property (go && !mem_enabled |=> mem_nak)
        else $error("access accepted before rom command");
    rom_enable_a: assert property (rom_done && rom_cmd != RC_NONE && !bus_reset |=> mem_enabled)
        else $error("rom command did not open memory");
    od_switch_a: assert property (rom_done && !bus_reset &&
        (rom_cmd == RC_OD_SKIP || rom_cmd == RC_OD_MATCH) |=> overdrive)
        else $error("overdrive not entered");
    user_ro_a: assert property (go && mem_wr && pg >= PG_EXC_FIRST |=> mem_nak && !sp_write)
        else $error("write to read-only page accepted");
    reserved_read_a: assert property (go && mem_enabled && !mem_wr && rsvd
        |=> mem_nak && reserved_hit)
        else $error("reserved read not refused");
    mission_guard_a: assert property (go && mem_enabled && mem_wr && mission_active &&
        pg == PG_REG && mem_addr[4:0] <= REG_PROT_LAST
        |=> mem_nak && mission_stop && !mission_active ##1 !mission_active)
        else $error("protected write in mission not stopped");
    scratch_path_a: assert property (go && mem_enabled && mem_wr && pg <= PG_REG &&
        !mission_active |=> mem_ack && sp_write)
        else $error("memory write skipped scratchpad");
    log_region_a: assert property (go && pg >= PG_LOG_FIRST && pg <= PG_LOG_LAST
        |=> region == RG_LOG)
        else $error("log page decoded wrongly");
    tx_order_a: assert property (tx_load |=> tx_bit == $past(tx_byte[0]))
        else $error("first sent bit not lsb");
    cover property (go && mem_wr |=> sp_write);
    cover property (mission_stop);
    cover property (rom_done && rom_cmd == RC_OD_MATCH);
    cover property (go && mem_enabled && !mem_wr && rsvd |=> reserved_hit);
endmodule // lgr_core_sva
`default_nettype wire

// >>> lgr_core_tb_top.sv
// lgr_core_tb_top: self-checking bench for lgr_core
// assumes: lgr_master_model plays the bus master; checker bound below
`timescale 1ns/100ps
`default_nettype none
module lgr_core_tb_top;
    import lgr_pkg::*;
    localparam logic [7:0] FAM_T = 8'h3C; // arbitrary value
    localparam logic [35:0] SER_T = 36'h0F1E2D3C4; // arbitrary value
    localparam logic [11:0] RNG_T = 12'h6B1; // arbitrary value
    typedef struct packed {logic wr; logic [7:0] pg; logic ack; lgr_region_type rg;} lgr_row_type;
    localparam lgr_row_type ROWS [13] = '{'{1'b0, 8'h00, 1'b1, RG_GP},
        '{1'b1, 8'h0F, 1'b1, RG_GP}, '{1'b1, 8'h10, 1'b1, RG_REG}, '{1'b0, 8'h11, 1'b1, RG_EXC},
        '{1'b1, 8'h13, 1'b0, RG_EXC}, '{1'b0, 8'h14, 1'b0, RG_RSVD}, '{1'b0, 8'h3F, 1'b0, RG_RSVD},
        '{1'b0, 8'h43, 1'b1, RG_HIST}, '{1'b0, 8'h44, 1'b0, RG_RSVD}, '{1'b0, 8'h7F, 1'b0, RG_RSVD},
        '{1'b1, 8'h80, 1'b0, RG_LOG}, '{1'b0, 8'hBF, 1'b1, RG_LOG}, '{1'b0, 8'hFF, 1'b0, RG_RSVD}};
    logic ref_clk, rst, mem_req, mem_wr, mission_start, tx_load, tx_shift;
    logic bus_reset, rom_done, id_bit_req, tx_bit, id_bit, id_valid, overdrive, mem_enabled;
    logic mem_ack, mem_nak, sp_write, reserved_hit, mission_active, mission_stop;
    logic [12:0] mem_addr;
    logic [7:0] tx_byte, id_crc, exp_crc;
    logic [63:0] word;
    lgr_rom_cmd_type rom_cmd;
    lgr_region_type region;
    int bad_count = 0, n_checks = 0, cyc = 0;
    lgr_core #(.FAMILY(FAM_T), .SERIAL(SER_T), .RANGE(RNG_T)) lgr_core_i (.ref_clk, .rst,
        .bus_reset, .rom_done, .rom_cmd, .mem_req, .mem_wr, .mem_addr, .mission_start,
        .id_bit_req, .tx_byte, .tx_load, .tx_shift, .tx_bit, .id_bit, .id_valid, .id_crc,
        .overdrive, .mem_enabled, .mem_ack, .mem_nak, .sp_write, .reserved_hit, .region,
        .mission_active, .mission_stop);
    lgr_master_model lgr_master_model_i (.ref_clk, .id_bit, .bus_reset, .rom_done, .rom_cmd,
        .id_bit_req);
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: value %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(posedge ref_clk) #1;
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        @(posedge ref_clk) #1;
    endtask
    task automatic access(input logic wr, input logic [7:0] pg, input logic [4:0] off);
        @(posedge ref_clk) #1;
        mem_req = 1'b1;
        mem_wr = wr;
        mem_addr = {pg, off};
        @(posedge ref_clk) #1;
        mem_req = 1'b0;
    endtask
    task automatic chk_answer(input logic ack, input logic sp);
        chk_bit(mem_ack, ack);
        chk_bit(mem_nak, !ack);
        chk_bit(sp_write, sp);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {rst, mem_req, mem_wr, mission_start, tx_load, tx_shift} = 6'h20;
        mem_addr = 13'h0000;
        tx_byte = 8'h00;
        do_reset();
        chk_vec({overdrive, mem_enabled, mission_active, region}, 64'h0);
        access(1'b0, 8'h00, 5'h00);
        chk_answer(1'b0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            do_reset();
            lgr_master_model_i.send_rom(lgr_rom_cmd_type'(i));
            chk_bit(mem_enabled, 1'b1);
            chk_bit(overdrive, i >= 5);
        end
        foreach (ROWS[k]) begin
            access(ROWS[k].wr, ROWS[k].pg, 5'h1F);
            chk_answer(ROWS[k].ack, ROWS[k].ack && ROWS[k].wr);
            chk_bit(reserved_hit, ROWS[k].rg == RG_RSVD);
            chk_vec(64'(region), 64'(ROWS[k].rg));
        end
        @(posedge ref_clk) #1 mission_start = 1'b1;
        @(posedge ref_clk) #1 mission_start = 1'b0;
        chk_bit(mission_active, 1'b1);
        access(1'b1, PG_REG, REG_STATUS);
        chk_answer(1'b1, 1'b1);
        chk_bit(mission_stop, 1'b0);
        chk_bit(mission_active, 1'b1);
        access(1'b0, PG_REG, 5'h00);
        chk_answer(1'b1, 1'b0);
        access(1'b1, PG_REG, REG_PROT_LAST);
        chk_answer(1'b0, 1'b0);
        chk_bit(mission_stop, 1'b1);
        @(posedge ref_clk) #1;
        chk_bit(mission_active, 1'b0);
        access(1'b1, PG_REG, 5'h00);
        chk_answer(1'b1, 1'b1);
        lgr_master_model_i.pulse_bus_reset();
        access(1'b0, 8'h00, 5'h00);
        chk_answer(1'b0, 1'b0);
        exp_crc = lgr_master_model_i.crc_over({8'h00, RNG_T, SER_T, FAM_T}, 56);
        lgr_master_model_i.read_id(word);
        chk_vec(word, {exp_crc, RNG_T, SER_T, FAM_T});
        chk_vec(64'(id_crc), 64'(exp_crc));
        chk_bit(id_valid, 1'b1);
        chk_vec(64'(lgr_master_model_i.crc_over(word, 64)), 64'h0);
        tx_byte = 8'hA6;
        tx_load = 1'b1;
        @(posedge ref_clk) #1 tx_load = 1'b0;
        for (int j = 0; j < 8; j++) begin
            chk_bit(tx_bit, tx_byte[j]);
            tx_shift = 1'b1;
            @(posedge ref_clk) #1 tx_shift = 1'b0;
        end
        print_verdict();
    end
endmodule // lgr_core_tb_top
bind lgr_core lgr_core_sva lgr_core_sva_i (.ref_clk, .rst, .bus_reset, .rom_done, .rom_cmd,
    .mem_req, .mem_wr, .mem_addr, .mission_start, .tx_byte, .tx_load, .tx_bit, .overdrive,
    .mem_enabled, .mem_ack, .mem_nak, .sp_write, .reserved_hit, .region, .mission_active,
    .mission_stop);
`default_nettype wire

// >>> lgr_crc8.sv
// lgr_crc8: serial crc-8 generator, one bit per enabled cycle
// assumes: caller clears it before the first bit
`timescale 1ns/100ps
`default_nettype none
module lgr_crc8 (
    input wire logic ref_clk, // clock
    input wire logic rst, // sync reset
    input wire logic clr, // clear all stages
    input wire logic shift_en, // shift one bit in
    input wire logic bit_in, // serial bit
    output logic [7:0] crc, // register contents
    output logic zero // register is all zero
);
    import lgr_pkg::*;
    logic [7:0] crc_reg, crc_next;
    always_comb begin
        crc_next = crc_reg;
        if (clr) begin
            crc_next = CRC_INIT;
        end else if (shift_en) begin
            crc_next = lgr_crc_step(crc_reg, bit_in);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            crc_reg <= CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end
    assign crc = crc_reg;
    assign zero = (crc_reg == CRC_INIT);
endmodule // lgr_crc8
`default_nettype wire

// >>> lgr_master_model.sv
// lgr_master_model: bus master side, issues rom commands and reads identity
// assumes: tasks called from the bench top; one clock
`timescale 1ns/100ps
`default_nettype none
module lgr_master_model
    import lgr_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic id_bit, // identity bit from device
    output logic bus_reset, // bus reset pulse
    output logic rom_done, // rom command done
    output lgr_pkg::lgr_rom_cmd_type rom_cmd, // rom command
    output logic id_bit_req // ask next identity bit
);
    import lgr_pkg::*;
    initial begin
        bus_reset = 1'b0;
        rom_done = 1'b0;
        rom_cmd = RC_NONE;
        id_bit_req = 1'b0;
    end
    // crc over the first n bits of w, lsb first
    function automatic logic [7:0] crc_over(input logic [63:0] w, input int n);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            fb = c[0] ^ w[i];
            c = {fb, c[7:1]} ^ {4'h0, fb, fb, 2'h0};
        end
        return c;
    endfunction
    task automatic send_rom(input lgr_rom_cmd_type c);
        @(posedge ref_clk) #1;
        rom_done = 1'b1;
        rom_cmd = c;
        @(posedge ref_clk) #1;
        rom_done = 1'b0;
        rom_cmd = RC_NONE;
    endtask
    task automatic pulse_bus_reset;
        @(posedge ref_clk) #1;
        bus_reset = 1'b1;
        @(posedge ref_clk) #1;
        bus_reset = 1'b0;
    endtask
    task automatic read_id(output logic [63:0] w);
        send_rom(RC_READ);
        @(posedge ref_clk) #1;
        for (int i = 0; i < 64; i++) begin
            w[i] = id_bit;
            id_bit_req = 1'b1;
            @(posedge ref_clk) #1;
            id_bit_req = 1'b0;
            @(posedge ref_clk) #1;
        end
    endtask
endmodule // lgr_master_model
`default_nettype wire

// >>> lgr_pkg.sv
// lgr_pkg: constants shared by the logger identity and memory-map core
// assumes: byte-wide transfers, 8-bit page number plus 5-bit byte offset
package lgr_pkg;
    localparam int ID_W = 64;
    localparam int FAM_W = 8;
    localparam int SER_W = 36;
    localparam int RNG_W = 12;
    localparam int CRC_W = 8;
    localparam int DATA_W = FAM_W + SER_W + RNG_W;
    localparam int FAM_LSB = 0;
    localparam int SER_LSB = FAM_W;
    localparam int RNG_LSB = FAM_W + SER_W;
    localparam int CRC_LSB = DATA_W;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam int BIT_CNT_W = 7;
    localparam logic [BIT_CNT_W-1:0] BIT_DATA_LAST = 7'h37;
    localparam logic [BIT_CNT_W-1:0] BIT_ALL_LAST = 7'h3F;
    localparam logic [7:0] PG_GP_LAST = 8'h0F;
    localparam logic [7:0] PG_REG = 8'h10;
    localparam logic [7:0] PG_EXC_FIRST = 8'h11;
    localparam logic [7:0] PG_EXC_LAST = 8'h13;
    localparam logic [7:0] PG_HIST_FIRST = 8'h40;
    localparam logic [7:0] PG_HIST_LAST = 8'h43;
    localparam logic [7:0] PG_LOG_FIRST = 8'h80;
    localparam logic [7:0] PG_LOG_LAST = 8'hBF;
    localparam logic [4:0] REG_PROT_LAST = 5'h13;
    localparam logic [4:0] REG_STATUS = 5'h14;
    localparam int HIST_BINS = 63;
    localparam int HIST_BYTES = 126;
    localparam int LOG_SAMPLES = 2048;
    localparam int EXC_ENTRIES = 24;
    localparam int EXC_BYTES = 96;
    localparam logic [7:0] RATE_MIN = 8'h01;
    localparam logic [7:0] RATE_MAX = 8'hFF;
    typedef enum logic [2:0] {
        RC_READ = 3'h0, RC_MATCH = 3'h1, RC_SEARCH = 3'h2, RC_COND = 3'h3,
        RC_SKIP = 3'h4, RC_OD_SKIP = 3'h5, RC_OD_MATCH = 3'h6, RC_NONE = 3'h7
    } lgr_rom_cmd_type;
    typedef enum logic [3:0] {
        RG_GP = 4'h0, RG_REG = 4'h1, RG_EXC = 4'h2, RG_HIST = 4'h3,
        RG_LOG = 4'h4, RG_RSVD = 4'h5
    } lgr_region_type;
    function automatic logic [7:0] lgr_crc_step(input logic [7:0] crc, input logic b);
        logic fb;
        fb = crc[0] ^ b;
        lgr_crc_step = (crc >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
    endfunction
endpackage
